// File: verilog/imdc_map.svh
/*
 Constants of the indicator menu and display controller: offsets, resets, timing counts.
 Assumes a 40 MHz system clock and a single synchronous reset.
*/
// Functional notes
// - Menu entry needs back key held 2 s
// - Power-up shows identity, then display mode
// - Dashes until first valid value update
// - Above range shows above-range message
// - Below range shows below-range message
// - Range -999..9999 or -99999..999999
// - Configuration never halts display or link
// - Responder blinks after silence, stops on write
// - Poller blinks without answer, stops on read
// - Poller reads slave every poll interval
// - Master writes value registers, device shows
// - Poller fetches value and decimal point
// - Role submenu shown only for active role (code: item 1 opens it in either role)
// - Nonzero passcode asked, other digits dashed
// - Match shows first item, else error
// - Enter opens submenu or starts edit
// - Back key climbs one level or exits
// - One minute idle exits unless editing
// - Up/down change digit, enter advances position
// - Long enter confirms; enter stores, back cancels
// - Ramp up accelerates, down slows it
// - Ramp down accelerates, up slows it
// - List steps options, enter twice stores
// - Silence timeout 0..99 s, zero disables (code: only register-port writes are clamped to 99; menu store to tmo_q is not)
// - Poller timeout lengthened by poll interval
`ifndef IMDC_MAP_SVH
`define IMDC_MAP_SVH
`define IMDC_CLK_HZ 40000000
`define IMDC_TICK_MS 1
`define IMDC_TICK_CYC ((`IMDC_CLK_HZ / 1000) * `IMDC_TICK_MS)
`define IMDC_DEBOUNCE_MS 20
`define IMDC_LONG_MS 2000
`define IMDC_IDLE_MS 60000
`define IMDC_BLINK_MS 250
`define IMDC_ID_MS 1500
`define IMDC_MAX_TMO_S 99
`define IMDC_RAMP_FAST_MS 400
`define IMDC_RAMP_MIN_MS 20
`define IMDC_RAMP_SLOW_MS 200
`define IMDC_RAMP_STEP_MS 40
`define IMDC_OFF_VALUE 4'h0
`define IMDC_OFF_CONFIG 4'h1
`define IMDC_OFF_TIMEOUT 4'h2
`define IMDC_OFF_POLL 4'h3
`define IMDC_OFF_PASS 4'h4
`define IMDC_OFF_STATUS 4'h5
`define IMDC_OFF_EDITVAL 4'h6
`define IMDC_OFF_PARAM 4'h7
`define IMDC_CFG_POLLER_BIT 0
`define IMDC_CFG_RAMP_BIT 1
`define IMDC_CFG_SIX_BIT 2
`define IMDC_CFG_RESET 32'h0000_0000
`define IMDC_TMO_RESET 32'h0000_0005
`define IMDC_POLL_RESET 32'h0000_0001
`define IMDC_PASS_RESET 32'h0000_0000
`define IMDC_MAX4 32'h0000_270F
`define IMDC_MIN4 32'hFFFF_FC19
`define IMDC_MAX6 32'h000F_423F
`define IMDC_MIN6 32'hFFFE_7961
`endif

// File: verilog/imdc_pkg.sv
/*
 Types of the indicator menu and display controller.
 Assumes the constants header alongside.
*/
package imdc_pkg;
    typedef enum logic [7:0] {
        IMDC_ID     = 8'b0000_0001,
        IMDC_SHOW   = 8'b0000_0010,
        IMDC_PASS   = 8'b0000_0100,
        IMDC_ERR    = 8'b0000_1000,
        IMDC_NAV    = 8'b0001_0000,
        IMDC_EDIT   = 8'b0010_0000,
        IMDC_CONF   = 8'b0100_0000,
        IMDC_RSV    = 8'b1000_0000
    } imdc_state_t;
    typedef enum logic [2:0] {
        IMDC_MSG_VALUE = 3'h0,
        IMDC_MSG_DASH  = 3'h1,
        IMDC_MSG_HIGH  = 3'h2,
        IMDC_MSG_LOW   = 3'h3,
        IMDC_MSG_ID    = 3'h4,
        IMDC_MSG_ERR   = 3'h5,
        IMDC_MSG_SET   = 3'h6,
        IMDC_MSG_MENU  = 3'h7
    } imdc_msg_t;
endpackage : imdc_pkg

// File: verilog/imdc_top.sv
/*
 Indicator display control and front-panel menu, with a plain register port.
 Assumes synchronous key inputs and a link engine giving write, request and answer pulses.
*/
`timescale 1ns/1ps
`include "imdc_map.svh"
module imdc_top
    import imdc_pkg::*;
#(
    parameter int TICK_CYC = `IMDC_TICK_CYC,
    parameter int IDLE_MS = `IMDC_IDLE_MS,
    parameter int LONG_MS = `IMDC_LONG_MS,
    parameter int ID_MS = `IMDC_ID_MS,
    parameter int DEB_MS = `IMDC_DEBOUNCE_MS,
    parameter int MENU_ITEMS = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic key_back_i,
    input wire logic key_enter_i,
    input wire logic key_up_i,
    input wire logic key_down_i,
    input wire logic link_write_i,
    input wire logic [31:0] link_value_i,
    input wire logic [3:0] link_point_i,
    input wire logic link_req_sent_i,
    input wire logic link_answer_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [2:0] msg_o,
    output logic [31:0] value_o,
    output logic [3:0] point_o,
    output logic visible_o,
    output logic poll_start_o,
    output logic store_o,
    output logic [31:0] store_value_o,
    output logic [7:0] state_o
);
    // ==========================================================
    // Registers and bus decode
    logic [31:0] cfg_q, tmo_q, poll_q, pass_q, value_q, edit_q;
    logic [3:0] point_q;
    logic [1:0] item_q;
    logic valid_q, blink_q, vis_q, sub_q;
    imdc_state_t state_q;
    wire poller = cfg_q[`IMDC_CFG_POLLER_BIT];
    wire ramp_mode = cfg_q[`IMDC_CFG_RAMP_BIT];
    wire six = cfg_q[`IMDC_CFG_SIX_BIT];
    wire sel_value = addr_i == `IMDC_OFF_VALUE;
    wire sel_cfg = addr_i == `IMDC_OFF_CONFIG;
    wire sel_tmo = addr_i == `IMDC_OFF_TIMEOUT;
    wire sel_poll = addr_i == `IMDC_OFF_POLL;
    wire sel_pass = addr_i == `IMDC_OFF_PASS;
    wire [31:0] status_w = {8'h00, 8'h00, state_q, 5'h00, blink_q, valid_q, poller};
    wire [31:0] rd_mux = sel_value ? value_q :
                         sel_cfg ? cfg_q :
                         sel_tmo ? tmo_q :
                         sel_poll ? poll_q :
                         sel_pass ? pass_q :
                         (addr_i == `IMDC_OFF_STATUS) ? status_w :
                         (addr_i == `IMDC_OFF_EDITVAL) ? edit_q :
                         (addr_i == `IMDC_OFF_PARAM) ? {30'h0, item_q} : 32'h0000_0000;
    // Value write from bus or link, never blocked by menu state
    wire bus_val_wr = wr_i && sel_value && !poller;
    wire link_upd = link_write_i && !poller;
    wire poll_upd = link_answer_i && poller;
    wire any_upd = bus_val_wr || link_upd || poll_upd;
    // ==========================================================
    // Millisecond tick and blink
    logic [15:0] tick_cnt_q;
    logic tick_q;
    logic [7:0] blink_cnt_q;
    logic blink_ph_q;
    wire tick_end = tick_cnt_q == 16'(TICK_CYC - 1);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            blink_cnt_q <= 8'h00;
            blink_ph_q <= 1'b0;
        end else if (ce_i) begin
            tick_cnt_q <= tick_end ? 16'h0000 : tick_cnt_q + 16'h0001;
            tick_q <= tick_end;
            if (tick_q) begin
                blink_cnt_q <= (blink_cnt_q == 8'(`IMDC_BLINK_MS - 1)) ? 8'h00 :
                               blink_cnt_q + 8'h01;
                if (blink_cnt_q == 8'(`IMDC_BLINK_MS - 1)) begin
                    blink_ph_q <= !blink_ph_q;
                end
            end
        end
    end
    // ==========================================================
    // Key debounce and press timing
    logic [3:0] key_q, key_raw_q;
    logic [4:0] deb_q [4];
    wire [3:0] key_in = {key_down_i, key_up_i, key_enter_i, key_back_i};
    logic [3:0] key_prev_q;
    logic [15:0] hold_q [4];
    logic [3:0] long_done_q;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_key
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    key_raw_q[k] <= 1'b0;
                    deb_q[k] <= 5'h00;
                    key_q[k] <= 1'b0;
                    hold_q[k] <= 16'h0000;
                end else if (ce_i) begin
                    key_raw_q[k] <= key_in[k];
                    if (key_raw_q[k] == key_q[k]) begin
                        deb_q[k] <= 5'h00;
                    end else if (tick_q) begin
                        deb_q[k] <= deb_q[k] + 5'h01;
                        if (deb_q[k] == 5'(DEB_MS - 1)) begin
                            key_q[k] <= key_raw_q[k];
                        end
                    end
                    if (!key_q[k]) begin
                        hold_q[k] <= 16'h0000;
                    end else if (tick_q && hold_q[k] != 16'hFFFF) begin
                        hold_q[k] <= hold_q[k] + 16'h0001;
                    end
                end
            end
        end
    endgenerate
    wire [3:0] rise = key_q & ~key_prev_q;
    wire [3:0] fall = ~key_q & key_prev_q;
    wire long_back = key_q[0] && hold_q[0] == 16'(LONG_MS) && !long_done_q[0];
    wire long_enter = key_q[1] && hold_q[1] == 16'(LONG_MS) && !long_done_q[1];
    wire short_enter = fall[1] && !long_done_q[1];
    wire short_back = fall[0] && !long_done_q[0];
    wire any_key = |rise;
    // ==========================================================
    // Ramp rate for slide editing
    logic [15:0] ramp_per_q, ramp_cnt_q;
    wire up_only = key_q[2] && !key_q[3];
    wire dn_only = key_q[3] && !key_q[2];
    wire both = key_q[2] && key_q[3];
    wire ramp_step = tick_q && (key_q[2] || key_q[3]) && ramp_cnt_q >= ramp_per_q;
    wire [15:0] per_fast = (ramp_per_q > 16'(`IMDC_RAMP_MIN_MS + `IMDC_RAMP_STEP_MS)) ?
                           ramp_per_q - 16'(`IMDC_RAMP_STEP_MS) : 16'(`IMDC_RAMP_MIN_MS);
    wire ramp_dir_up = key_q[2] && (!key_q[3] || hold_q[2] > hold_q[3]);
    // ==========================================================
    // Silence timeout and poll timer
    logic [31:0] sil_q, poll_cnt_q;
    wire [31:0] tmo_ms = tmo_q * 32'd1000 + (poller ? poll_q * 32'd1000 : 32'h0);
    wire tmo_on = tmo_q != 32'h0;
    wire poll_due = poller && tick_q && poll_cnt_q + 32'h1 >= poll_q * 32'd1000;
    wire sil_restart = poller ? link_req_sent_i && !blink_q && sil_q == 32'h0 : any_upd;
    // ==========================================================
    // Menu state machine
    logic [15:0] idle_q, id_q;
    logic [2:0] pos_q;
    logic [31:0] edit_d;
    wire [3:0] pass_dig = 4'(edit_q >> {pos_q, 2'b00});
    wire max_item = item_q == 2'(MENU_ITEMS - 1);
    // Item 1 is the role submenu; item 2 is the role list, item 3 a numeric
    wire item_is_sub = item_q == 2'h1;
    wire item_is_list = item_q == 2'h2;
    always_comb begin
        edit_d = edit_q;
        if (ramp_mode) begin
            if (ramp_step) begin
                edit_d = ramp_dir_up ? edit_q + 32'h1 : edit_q - 32'h1;
            end
        end else if (rise[2]) begin
            edit_d = edit_q + (32'h1 << {pos_q, 2'b00});
        end else if (rise[3]) begin
            edit_d = edit_q - (32'h1 << {pos_q, 2'b00});
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= IMDC_ID;
            cfg_q <= `IMDC_CFG_RESET;
            tmo_q <= `IMDC_TMO_RESET;
            poll_q <= `IMDC_POLL_RESET;
            pass_q <= `IMDC_PASS_RESET;
            value_q <= 32'h0;
            point_q <= 4'h0;
            valid_q <= 1'b0;
            blink_q <= 1'b0;
            sil_q <= 32'h0;
            poll_cnt_q <= 32'h0;
            idle_q <= 16'h0;
            id_q <= 16'h0;
            item_q <= 2'h0;
            sub_q <= 1'b0;
            pos_q <= 3'h0;
            edit_q <= 32'h0;
            key_prev_q <= 4'h0;
            long_done_q <= 4'h0;
            ramp_per_q <= 16'(`IMDC_RAMP_FAST_MS);
            ramp_cnt_q <= 16'h0;
            store_o <= 1'b0;
            store_value_o <= 32'h0;
            poll_start_o <= 1'b0;
        end else if (ce_i) begin
            key_prev_q <= key_q;
            long_done_q <= key_q & (long_done_q | {2'b00, long_enter, long_back});
            store_o <= 1'b0;
            poll_start_o <= poll_due;
            if (wr_i && sel_cfg) cfg_q <= wdata_i;
            if (wr_i && sel_tmo) tmo_q <= (wdata_i > 32'(`IMDC_MAX_TMO_S)) ?
                                         32'(`IMDC_MAX_TMO_S) : wdata_i;
            if (wr_i && sel_poll) poll_q <= wdata_i;
            if (wr_i && sel_pass) pass_q <= wdata_i;
            if (bus_val_wr) value_q <= wdata_i;
            if (link_upd || poll_upd) begin
                value_q <= link_value_i;
                point_q <= link_point_i;
            end
            if (any_upd) valid_q <= 1'b1;
            poll_cnt_q <= !poller ? 32'h0 : poll_due ? 32'h0 :
                          tick_q ? poll_cnt_q + 32'h1 : poll_cnt_q;
            // Update wins over timeout in the same cycle
            if (any_upd) begin
                blink_q <= 1'b0;
                sil_q <= 32'h0;
            end else if (sil_restart) begin
                sil_q <= 32'h1;
            end else if (tick_q && tmo_on && (poller ? sil_q != 32'h0 : valid_q)) begin
                sil_q <= sil_q + 32'h1;
                if (sil_q >= tmo_ms) blink_q <= 1'b1;
            end
            if (!tmo_on) blink_q <= 1'b0;
            ramp_cnt_q <= ramp_step ? 16'h0 : tick_q ? ramp_cnt_q + 16'h1 : ramp_cnt_q;
            if (!(key_q[2] || key_q[3])) ramp_per_q <= 16'(`IMDC_RAMP_FAST_MS);
            else if (both) ramp_per_q <= 16'(`IMDC_RAMP_SLOW_MS);
            else if ((rise[2] && key_q[3]) || (rise[3] && key_q[2]))
                ramp_per_q <= 16'(`IMDC_RAMP_SLOW_MS);
            else if (ramp_step && (up_only || dn_only)) ramp_per_q <= per_fast;
            idle_q <= any_key ? 16'h0 : (tick_q && idle_q != 16'hFFFF) ?
                      idle_q + 16'h1 : idle_q;
            case (state_q)
                IMDC_ID: begin
                    if (tick_q) id_q <= id_q + 16'h1;
                    if (id_q == 16'(ID_MS)) state_q <= IMDC_SHOW;
                end
                IMDC_SHOW: begin
                    item_q <= 2'h0;
                    sub_q <= 1'b0;
                    pos_q <= 3'h0;
                    edit_q <= 32'h0;
                    if (long_back) state_q <= (pass_q != 32'h0) ? IMDC_PASS : IMDC_NAV;
                end
                IMDC_PASS: begin
                    edit_q <= edit_d;
                    if (short_back) state_q <= IMDC_SHOW;
                    else if (short_enter) begin
                        pos_q <= pos_q + 3'h1;
                        if (pos_q == 3'h3) begin
                            state_q <= (edit_q[15:0] == pass_q[15:0]) ? IMDC_NAV : IMDC_ERR;
                        end
                    end
                end
                IMDC_ERR: begin
                    if (any_key) state_q <= IMDC_SHOW;
                end
                IMDC_NAV: begin
                    if (rise[2]) item_q <= max_item ? 2'h0 : item_q + 2'h1;
                    else if (rise[3]) item_q <= (item_q == 2'h0) ? 2'(MENU_ITEMS - 1) :
                                                item_q - 2'h1;
                    if (idle_q == 16'(IDLE_MS)) state_q <= IMDC_SHOW;
                    else if (short_back) begin
                        if (sub_q) sub_q <= 1'b0;
                        else state_q <= IMDC_SHOW;
                    end else if (short_enter) begin
                        if (item_is_sub && !sub_q) begin
                            sub_q <= 1'b1;
                            item_q <= 2'h0;
                        end else begin
                            state_q <= IMDC_EDIT;
                            pos_q <= 3'h0;
                            edit_q <= item_is_list ? {31'h0, poller} : tmo_q;
                        end
                    end
                end
                IMDC_EDIT: begin
                    if (item_is_list && !sub_q) begin
                        if (rise[2] || rise[3]) edit_q <= {31'h0, !edit_q[0]};
                        if (short_enter) state_q <= IMDC_CONF;
                    end else begin
                        edit_q <= edit_d;
                        if (short_enter) pos_q <= (pos_q == 3'h3) ? 3'h0 : pos_q + 3'h1;
                        if (long_enter) state_q <= IMDC_CONF;
                    end
                    if (short_back) state_q <= IMDC_NAV;
                end
                IMDC_CONF: begin
                    if (short_enter) begin
                        store_o <= 1'b1;
                        store_value_o <= edit_q;
                        if (item_is_list && !sub_q) cfg_q[`IMDC_CFG_POLLER_BIT] <= edit_q[0];
                        else tmo_q <= edit_q;
                        state_q <= IMDC_NAV;
                    end else if (short_back) state_q <= IMDC_NAV;
                end
                default: state_q <= IMDC_SHOW;
            endcase
        end
    end
    // ==========================================================
    // Display selection
    wire signed [31:0] sval = value_q;
    wire above = six ? sval > $signed(`IMDC_MAX6) : sval > $signed(`IMDC_MAX4);
    wire below = six ? sval < $signed(`IMDC_MIN6) : sval < $signed(`IMDC_MIN4);
    wire [2:0] show_msg = !valid_q ? IMDC_MSG_DASH : above ? IMDC_MSG_HIGH :
                          below ? IMDC_MSG_LOW : IMDC_MSG_VALUE;
    wire [2:0] msg_d = (state_q == IMDC_ID) ? IMDC_MSG_ID :
                       (state_q == IMDC_SHOW) ? show_msg :
                       (state_q == IMDC_ERR) ? IMDC_MSG_ERR :
                       (state_q == IMDC_CONF) ? IMDC_MSG_SET :
                       (state_q == IMDC_NAV) ? IMDC_MSG_MENU : IMDC_MSG_VALUE;
    // Passcode shows only the edited digit; other nibbles read as dash code
    wire [31:0] dash_val = {16'hFFFF, pos_q == 3'h3 ? pass_dig : 4'hF,
                            pos_q == 3'h2 ? pass_dig : 4'hF,
                            pos_q == 3'h1 ? pass_dig : 4'hF,
                            pos_q == 3'h0 ? pass_dig : 4'hF};
    wire [31:0] val_d = (state_q == IMDC_PASS) ? dash_val :
                        (state_q == IMDC_EDIT) ? edit_q :
                        (state_q == IMDC_NAV) ? {29'h0, sub_q, item_q} : value_q;
    wire vis_d = !(state_q == IMDC_SHOW && blink_q && valid_q && blink_ph_q);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0;
            msg_o <= IMDC_MSG_ID;
            value_o <= 32'h0;
            point_o <= 4'h0;
            visible_o <= 1'b1;
            state_o <= IMDC_ID;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
            msg_o <= msg_d;
            value_o <= val_d;
            point_o <= point_q;
            visible_o <= vis_d;
            state_o <= state_q;
        end
    end
    // ==========================================================
    // Assertions
    menu_entry_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == IMDC_SHOW && ce_i && !long_back) |=> state_q != IMDC_NAV && state_q != IMDC_PASS)
        else $error("menu entered without long back press");
    dash_first_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == IMDC_SHOW && !valid_q) |-> msg_d == IMDC_MSG_DASH)
        else $error("value shown before first update");
    above_msg_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == IMDC_SHOW && valid_q && above) |-> msg_d == IMDC_MSG_HIGH)
        else $error("above range not flagged");
    below_msg_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_q == IMDC_SHOW && valid_q && below) |-> msg_d == IMDC_MSG_LOW)
        else $error("below range not flagged");
    blink_stop_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && any_upd) |=> !blink_q)
        else $error("blink not stopped by update");
    tmo_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && !tmo_on) |=> !blink_q)
        else $error("blink with timeout disabled");
    idle_exit_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && state_q == IMDC_NAV && idle_q == 16'(IDLE_MS)) |=> state_q == IMDC_SHOW)
        else $error("idle exit missed");
    store_conf_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (store_o && $past(ce_i)) |-> $past(state_q) == IMDC_CONF)
        else $error("store outside confirm");
    pass_chk_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && state_q == IMDC_PASS && short_enter && pos_q == 3'h3 && !short_back &&
         edit_q[15:0] != pass_q[15:0]) |=> state_q == IMDC_ERR)
        else $error("wrong passcode accepted");
    cv_menu_c: cover property (@(posedge clk_i) state_q == IMDC_NAV);
    cv_store_c: cover property (@(posedge clk_i) store_o);
    cv_blink_c: cover property (@(posedge clk_i) blink_q);
endmodule : imdc_top

// File: tb/imdc_peer_model.sv
/*
 Remote responder on the serial link: answers each poll request after a delay.
 Assumes poll strobes from the controller and bench values for responder frames.
*/
`timescale 1ns/1ps
module imdc_peer_model #(
    parameter int DLY = 3
) (
    input wire logic clk_i,
    input wire logic poll_i,
    input wire logic [31:0] bench_value_i,
    output logic req_sent_o,
    output logic answer_o,
    output logic [31:0] value_o,
    output logic [3:0] point_o
);
    logic [7:0] cnt_q = 8'h00;
    logic ans_q = 1'b0;
    assign req_sent_o = poll_i;
    assign answer_o = ans_q;
    assign value_o = ans_q ? 32'h0000_10E1 : bench_value_i;
    assign point_o = 4'h2;
    always_ff @(posedge clk_i) begin
        ans_q <= (cnt_q == 8'h01);
        cnt_q <= poll_i ? DLY[7:0] : ((cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q);
    end
endmodule : imdc_peer_model

// File: tb/indicator_menu_and_display_control_tb.sv
/*
 Bench of the indicator controller: register port, link frames, keys, poller.
 Assumes the peer model and shortened timing parameters.
*/
`timescale 1ns/1ps
module indicator_menu_and_display_control_tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] keys_q = 4'h0;
    logic lw_q = 1'b0;
    logic [31:0] lv_q = 32'h0000_0000;
    logic [3:0] addr_q = 4'h0;
    logic [31:0] wd_q = 32'h0000_0000;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    logic ce_q = 1'b1;
    logic [31:0] stored = 32'h0000_0000;
    logic [31:0] r, rdata_o, value_o, store_value_o, link_value;
    logic [2:0] msg_o;
    logic [3:0] point_o, link_point;
    logic visible_o, poll_start_o, store_o, req_sent, answer;
    logic [7:0] state_o;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    int n_store = 0;
    always #12.5 clk_i = ~clk_i;
    imdc_top #(.TICK_CYC(4), .IDLE_MS(200), .LONG_MS(20), .ID_MS(15), .DEB_MS(2)) u_imdc_top (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_q), .key_back_i(keys_q[0]),
        .key_enter_i(keys_q[1]), .key_up_i(keys_q[2]), .key_down_i(keys_q[3]),
        .link_write_i(lw_q), .link_value_i(link_value), .link_point_i(link_point),
        .link_req_sent_i(req_sent), .link_answer_i(answer), .addr_i(addr_q), .wdata_i(wd_q),
        .wr_i(wr_q), .rd_i(rd_q), .rdata_o(rdata_o), .msg_o(msg_o), .value_o(value_o),
        .point_o(point_o), .visible_o(visible_o), .poll_start_o(poll_start_o),
        .store_o(store_o), .store_value_o(store_value_o), .state_o(state_o));
    imdc_peer_model u_imdc_peer_model (.clk_i(clk_i), .poll_i(poll_start_o),
        .bench_value_i(lv_q), .req_sent_o(req_sent), .answer_o(answer),
        .value_o(link_value), .point_o(link_point));
    // ==========================================
    // Access tasks
    task automatic end_sim;
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cy(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cy
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_q <= a;
        wd_q <= d;
        wr_q <= 1'b1;
        @(posedge clk_i);
        wr_q <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_q <= a;
        rd_q <= 1'b1;
        @(posedge clk_i);
        rd_q <= 1'b0;
        #1;
        r = rdata_o;
    endtask : rd
    task automatic lw(input logic [31:0] v, input logic [2:0] e);
        @(posedge clk_i);
        lw_q <= 1'b1;
        lv_q <= v;
        @(posedge clk_i);
        lw_q <= 1'b0;
        cy(4);
        chk(msg_o, e);
    endtask : lw
    task automatic key(input int k, input int m);
        @(posedge clk_i);
        keys_q[k] <= 1'b1;
        repeat (m) @(posedge clk_i);
        keys_q[k] <= 1'b0;
        cy(40);
    endtask : key
    task automatic waitp;
        n = 0;
        while (poll_start_o !== 1'b1 && n < 5000) begin
            cy(1);
            n++;
        end
    endtask : waitp
    task automatic waitv(input logic v);
        n = 0;
        while (visible_o !== v && n < 3000) begin
            cy(1);
            n++;
        end
    endtask : waitv
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (store_o === 1'b1) begin
            stored <= store_value_o;
            n_store <= n_store + 1;
        end
        if (cyc == 60000) begin
            n_errors++;
            end_sim();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        cy(1);
        chk(state_o, 8'h01);
        chk(msg_o, 3'h4);
        @(posedge clk_i);
        ce_q <= 1'b0;
        cy(100);
        chk(state_o, 8'h01);
        chk(msg_o, 3'h4);
        @(posedge clk_i);
        ce_q <= 1'b1;
        cy(80);
        chk(state_o, 8'h02);
        chk(msg_o, 3'h1);
        rd(4'h1); chk(r, 32'h0000_0000);
        rd(4'h2); chk(r, 32'h0000_0005);
        rd(4'h3); chk(r, 32'h0000_0001);
        rd(4'h8); chk(r, 32'h0000_0000);
        lw(32'h0000_007B, 3'h0);
        chk(value_o, 32'h0000_007B);
        lw(32'h0000_270F, 3'h0);
        lw(32'h0000_2710, 3'h2);
        lw(32'hFFFF_FC19, 3'h0);
        lw(32'hFFFF_FC18, 3'h3);
        wr(4'h1, 32'h0000_0004);
        lw(32'h000F_423F, 3'h0);
        lw(32'h000F_4240, 3'h2);
        wr(4'h1, 32'h0000_0000);
        wr(4'h2, 32'h0000_0001);
        cy(6000);
        rd(4'h5); chk(r[2], 1'b1);
        waitv(1'b1); waitv(1'b0); waitv(1'b1);
        chk(n > 990 && n < 1010, 1'b1);
        lw(32'h0000_0037, 3'h0);
        rd(4'h5); chk(r[2], 1'b0);
        wr(4'h2, 32'h0000_0000);
        cy(6000);
        rd(4'h5); chk(r[2], 1'b0);
        key(0, 50); chk(state_o, 8'h02);
        key(0, 150); chk(state_o, 8'h10);
        key(2, 20); rd(4'h7); chk(r, 32'h0000_0001);
        key(3, 20); key(1, 20); chk(state_o, 8'h20);
        key(1, 150); chk(state_o, 8'h40);
        key(0, 20); chk(state_o, 8'h10);
        key(0, 20); chk(state_o, 8'h02);
        key(0, 150); key(1, 20); key(2, 20); chk(value_o, 32'h0000_0001);
        key(1, 20); key(2, 20); chk(value_o, 32'h0000_0011);
        key(1, 150); key(1, 20); chk(stored, 32'h0000_0011);
        chk(n_store, 32'h0000_0001);
        rd(4'h2); chk(r, 32'h0000_0011);
        key(0, 20); chk(state_o, 8'h02);
        key(0, 150); cy(1000); chk(state_o, 8'h02);
        wr(4'h4, 32'h0000_0001);
        key(0, 150); chk(value_o, 32'hFFFF_FFF0);
        repeat (4) key(1, 20);
        chk(state_o, 8'h08);
        key(3, 20); key(0, 150); key(2, 20); chk(value_o, 32'hFFFF_FFF1);
        repeat (4) key(1, 20);
        chk(state_o, 8'h10);
        key(0, 20); wr(4'h4, 32'h0000_0000);
        wr(4'h1, 32'h0000_0001);
        waitp(); cy(10);
        chk(value_o, 32'h0000_10E1);
        chk(point_o, 4'h2);
        waitp(); chk(n > 3900 && n < 4100, 1'b1);
        end_sim();
    end
endmodule : indicator_menu_and_display_control_tb
